// ---- bench/ebc_ctrl_checker.sv ----
// assertions on the external bus control ports
`timescale 1ns/1ns
`default_nettype none
module ebc_ctrl_checker
    import ebc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic ready,
    input wire logic hold_req_n,
    input wire logic outputs_off_n,
    input wire logic req_ack,
    input wire logic memory_strobe_n,
    input wire logic io_strobe_n,
    input wire logic rw,
    input wire logic rw_oe_n,
    input wire logic memory_strobe_oe_n,
    input wire logic io_strobe_oe_n,
    input wire logic space_sel_oe_n,
    input wire logic bus_grant_ack_n,
    input wire logic bus_grant_ack_oe_n,
    input wire logic wait_states_done_n,
    input wire logic wait_states_done_oe_n,
    input wire logic instr_fetch_oe_n,
    input wire logic [1:0] req_space,
    input wire logic [WS_W-1:0] ws_data,
    input wire logic [WS_W-1:0] ws_prog,
    input wire logic [WS_W-1:0] ws_io
);
    logic [WS_W-1:0] ws_cur;
    assign ws_cur = req_space == SP_IO ? ws_io : req_space == SP_PROG ? ws_prog : ws_data;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    AST_MEM: assert property (!memory_strobe_n |-> req_valid && req_space != SP_IO)
        else $error("memory strobe");
    AST_IO: assert property (!io_strobe_n |-> req_valid && req_space == SP_IO)
        else $error("io strobe");
    AST_RW: assert property ($fell(rw) |-> req_write)
        else $error("direction");
    AST_HOLD: assert property (!bus_grant_ack_n |->
        memory_strobe_oe_n && io_strobe_oe_n && rw_oe_n && space_sel_oe_n) else $error("hold");
    AST_GRANT: assert property ($changed(bus_grant_ack_n) |->
        bus_grant_ack_n == $past(hold_req_n)) else $error("grant");
    AST_OFF: assert property (!outputs_off_n |=> bus_grant_ack_oe_n &&
        wait_states_done_oe_n && instr_fetch_oe_n && memory_strobe_oe_n) else $error("off");
    AST_DONE: assert property (!wait_states_done_n |-> ws_cur >= WS_READY_MIN &&
        !(memory_strobe_n && io_strobe_n)) else $error("wait done");
    AST_READY: assert property (req_ack && ws_cur >= WS_READY_MIN |-> $past(ready))
        else $error("ready");
    AST_ZERO: assert property ($fell(memory_strobe_n) && ws_cur == WS_ZERO |=> req_ack)
        else $error("zero wait");
    cover property (req_ack && ws_cur >= WS_READY_MIN);
    cover property (!bus_grant_ack_n);
    cover property (!wait_states_done_n ##1 wait_states_done_n);
endmodule
`default_nettype wire

// ---- bench/ebc_mem_model.sv ----
// far-side device answering on the ready line
`timescale 1ns/1ns
`default_nettype none
module ebc_mem_model (
    input wire logic ref_clk,
    input wire logic strobe_n,
    input wire logic done_n,
    input wire logic [1:0] mode,
    output logic ready
);
    logic [3:0] cnt_ff;
    always_ff @(posedge ref_clk) cnt_ff <= strobe_n ? 4'h0 : cnt_ff + 4'h1;
    // slow device is low even when idle, no kinder than a real one
    assign ready = mode == 2'h2 ? done_n : (mode == 2'h0 || cnt_ff > 4'h6);
endmodule
`default_nettype wire

// ---- bench/external_bus_control_bench.sv ----
// bench for the external bus control block
`timescale 1ns/1ns
`default_nettype none
module external_bus_control_bench;
    import ebc_pkg::*;
    logic ref_clk = 0, rstn = 0, req_valid = 0, req_write = 0, req_fetch = 0, hold_req_n = 1;
    logic outputs_off_n = 1, ready, req_ack, memory_strobe_n, io_strobe_n, rw, rw_oe_n;
    logic memory_strobe_oe_n, io_strobe_oe_n, data_space_sel_n, program_space_sel_n;
    logic io_space_sel_n, space_sel_oe_n, bus_grant_ack_n, bus_grant_ack_oe_n, instr_fetch_n;
    logic wait_states_done_n, wait_states_done_oe_n, instr_fetch_oe_n;
    logic [1:0] req_space = SP_DATA, mode = 2'h0;
    logic [WS_W-1:0] ws_data = WS_ZERO, ws_prog = WS_ZERO, ws_io = WS_ZERO;
    int n_mismatch = 0, tests_run = 0, cyc, lows, base;
    ebc_ctrl dut (.*);
    ebc_mem_model mem (.ref_clk, .strobe_n(memory_strobe_n & io_strobe_n),
        .done_n(wait_states_done_n), .mode, .ready);
    task automatic check(input string what, input logic [7:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic acc(input logic [1:0] sp, input logic wr, fe, input logic [2:0] n);
        int i;
        @(posedge ref_clk);
        {ws_data, ws_prog, ws_io, req_space, req_write, req_fetch} <= {n, n, n, sp, wr, fe};
        req_valid <= 1'b1;
        lows = 0;
        @(posedge ref_clk);
        #1;
        check("pins", {memory_strobe_n, io_strobe_n, rw, instr_fetch_n, data_space_sel_n,
            program_space_sel_n, io_space_sel_n}, {sp == SP_IO, sp != SP_IO, !wr, !fe,
            3'h7 ^ (3'h4 >> sp)});
        for (i = 1; i < 60 && req_ack !== 1'b1; i++) begin
            lows += !wait_states_done_n;
            @(posedge ref_clk);
            #1;
        end
        cyc = i;
        req_valid <= 1'b0;
        check("strobe end", memory_strobe_n & io_strobe_n, 1'b1);
        if (i == 60) begin
            n_mismatch++;
            give_verdict();
        end
    endtask
    task automatic t_strobes();
        for (int s = 0; s < 3; s++) begin
            for (int n = 0; n < 2; n++) begin
                acc(s[1:0], n[0], s == 1, n[2:0]);
                check("length", cyc, n + 2);
            end
        end
        $display("strobes done");
    endtask
    task automatic t_ready();
        acc(SP_DATA, 1'b0, 1'b0, 3'h3);
        base = cyc;
        check("ready length", base, 6);
        check("done low", lows, 2);
        mode <= 2'h1;
        acc(SP_IO, 1'b0, 1'b0, 3'h3);
        check("stall", cyc > base, 1'b1);
        acc(SP_IO, 1'b1, 1'b0, 3'h1);
        check("ignored", cyc, 3);
        mode <= 2'h2;
        acc(SP_PROG, 1'b0, 1'b0, 3'h3);
        check("loopback", cyc, base);
        $display("ready done");
    endtask
    task automatic t_hold();
        @(posedge ref_clk);
        hold_req_n <= 1'b0;
        req_valid <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        check("hold", {bus_grant_ack_n, memory_strobe_oe_n, rw_oe_n, space_sel_oe_n,
            memory_strobe_n}, 5'h0F);
        @(posedge ref_clk);
        {hold_req_n, req_valid} <= 2'h2;
        repeat (2) @(posedge ref_clk);
        #1;
        check("unhold", {bus_grant_ack_n, rw_oe_n}, 2'h2);
        $display("hold done");
    endtask
    task automatic t_off();
        @(posedge ref_clk);
        outputs_off_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check("off", {bus_grant_ack_oe_n, wait_states_done_oe_n, instr_fetch_oe_n,
            io_strobe_oe_n}, 4'hF);
        $display("off done");
    endtask
    initial forever #2 ref_clk = ~ref_clk;
    initial begin
        #9;
        check("reset", {bus_grant_ack_n, memory_strobe_n, io_strobe_n}, 3'h7);
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        t_strobes();
        t_ready();
        t_hold();
        t_off();
        give_verdict();
    end
endmodule
bind ebc_ctrl ebc_ctrl_checker chk (.*);
`default_nettype wire

// ---- hw/ebc_ctrl.sv ----
// control strobes, wait states and hold handshake of the external bus
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - memory strobe high except during a data or program space access
// - memory strobe, io strobe and direction float in hold or when outputs off
// - ready low at sampling extends access one cycle, then samples again
// - ready only honoured with two or more wait states, after they elapse
// - direction high for read, low only during a write
// - io strobe high except during an io space access
// - outside master requests hold; once acknowledged lines go high impedance
// - hold acknowledge shows hold state with lines floating
// - hold acknowledge high during reset, floats when outputs off
// - wait complete low at first wait state, high at start of last
// - wait complete looped to ready gives one extra external wait state
// - instruction fetch low while address is an instruction address; floats when off
// - wait complete floats when outputs off
// - space selects high except the addressed one; float in hold
module ebc_ctrl
    import ebc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic req_valid,
    input wire logic [1:0] req_space,
    input wire logic req_write,
    input wire logic req_fetch,
    input wire logic [WS_W-1:0] ws_data,
    input wire logic [WS_W-1:0] ws_prog,
    input wire logic [WS_W-1:0] ws_io,
    input wire logic ready,
    input wire logic hold_req_n,
    input wire logic outputs_off_n,
    output logic req_ack,
    output logic memory_strobe_n,
    output logic memory_strobe_oe_n,
    output logic io_strobe_n,
    output logic io_strobe_oe_n,
    output logic rw,
    output logic rw_oe_n,
    output logic data_space_sel_n,
    output logic program_space_sel_n,
    output logic io_space_sel_n,
    output logic space_sel_oe_n,
    output logic bus_grant_ack_n,
    output logic bus_grant_ack_oe_n,
    output logic wait_states_done_n,
    output logic wait_states_done_oe_n,
    output logic instr_fetch_n,
    output logic instr_fetch_oe_n
);
    // whole state in one record: one process fills it, one registers it
    typedef struct packed {
        ebc_state_t st;
        logic [WS_W-1:0] cnt;
        logic use_ready;
        logic ack;
        logic mem_stb;
        logic io_stb;
        logic rw;
        logic ctl_oe_n;
        logic dsel;
        logic psel;
        logic isel;
        logic grant;
        logic grant_oe_n;
        logic wdone;
        logic wdone_oe_n;
        logic fetch;
        logic fetch_oe_n;
    } ebc_regs_t;

    ebc_regs_t st_ff;
    ebc_regs_t nxt_st;
    logic [WS_W-1:0] ws_sel;
    logic [2:0] space_hit;
    logic off;

    // unused space code falls back to data timing
    always_comb begin
        unique case (req_space)
            SP_DATA: ws_sel = ws_data;
            SP_PROG: ws_sel = ws_prog;
            SP_IO: ws_sel = ws_io;
            default: ws_sel = ws_data;
        endcase
    end

    // one compare per space; bit index is the space code
    for (genvar g = 0; g < 3; g++) begin : g_space
        assign space_hit[g] = (req_space == 2'(g));
    end

    assign off = ~outputs_off_n;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = PIN_LOW;

        unique case (st_ff.st)
            EBC_IDLE: begin
                nxt_st.mem_stb = PIN_HIGH;
                nxt_st.io_stb = PIN_HIGH;
                nxt_st.rw = PIN_HIGH;
                nxt_st.dsel = PIN_HIGH;
                nxt_st.psel = PIN_HIGH;
                nxt_st.isel = PIN_HIGH;
                nxt_st.fetch = PIN_HIGH;
                nxt_st.wdone = PIN_HIGH;

                // hold taken only from idle, so a started access always ends
                if (!hold_req_n) begin
                    nxt_st.st = EBC_HOLD;
                    nxt_st.grant = PIN_LOW;
                end else if (req_valid) begin
                    // access starts: strobe, space select, direction in one go
                    nxt_st.st = EBC_WAIT;
                    nxt_st.cnt = ws_sel;
                    // fewer than two wait states: ready is never looked at
                    nxt_st.use_ready = (ws_sel >= WS_READY_MIN);
                    nxt_st.mem_stb = space_hit[SP_IO];
                    nxt_st.io_stb = ~space_hit[SP_IO];
                    nxt_st.rw = ~req_write;
                    nxt_st.dsel = ~space_hit[SP_DATA];
                    nxt_st.psel = ~space_hit[SP_PROG];
                    nxt_st.isel = ~space_hit[SP_IO];
                    nxt_st.fetch = ~req_fetch;
                    nxt_st.wdone = (ws_sel < WS_READY_MIN);
                end
            end

            EBC_WAIT: begin
                if (st_ff.cnt == WS_ZERO) begin
                    // strobe phase done; ready extension only after it
                    if (st_ff.use_ready) begin
                        nxt_st.st = EBC_READY;
                    end else begin
                        nxt_st.st = EBC_IDLE;
                        nxt_st.ack = PIN_HIGH;
                        nxt_st.mem_stb = PIN_HIGH;
                        nxt_st.io_stb = PIN_HIGH;
                    end
                end else begin
                    nxt_st.cnt = st_ff.cnt - WS_ONE;
                    // done line rises as the last software wait state starts
                    if (st_ff.use_ready && st_ff.cnt == WS_READY_MIN) begin
                        nxt_st.wdone = PIN_HIGH;
                    end
                end
            end

            EBC_READY: begin
                // this state is the one external wait state; a looped-back
                // done line is already high here, so it adds no more
                if (ready) begin
                    nxt_st.st = EBC_IDLE;
                    nxt_st.ack = PIN_HIGH;
                    nxt_st.mem_stb = PIN_HIGH;
                    nxt_st.io_stb = PIN_HIGH;
                end
            end

            EBC_HOLD: begin
                if (hold_req_n) begin
                    nxt_st.st = EBC_IDLE;
                    nxt_st.grant = PIN_HIGH;
                end
            end
        endcase

        // pins float a cycle after off falls: every pin leaves a flop
        nxt_st.ctl_oe_n = off | (nxt_st.st == EBC_HOLD);
        nxt_st.grant_oe_n = off;
        nxt_st.wdone_oe_n = off;
        nxt_st.fetch_oe_n = off;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '{
                st: EBC_IDLE,
                cnt: WS_ZERO,
                use_ready: PIN_LOW,
                ack: PIN_LOW,
                mem_stb: PIN_HIGH,
                io_stb: PIN_HIGH,
                rw: PIN_HIGH,
                ctl_oe_n: PIN_LOW,
                dsel: PIN_HIGH,
                psel: PIN_HIGH,
                isel: PIN_HIGH,
                grant: PIN_HIGH,
                grant_oe_n: PIN_LOW,
                wdone: PIN_HIGH,
                wdone_oe_n: PIN_LOW,
                fetch: PIN_HIGH,
                fetch_oe_n: PIN_LOW
            };
        end else begin
            st_ff <= nxt_st;
        end
    end

    // every pin comes straight from a state flop
    assign req_ack = st_ff.ack;
    assign memory_strobe_n = st_ff.mem_stb;
    assign memory_strobe_oe_n = st_ff.ctl_oe_n;
    assign io_strobe_n = st_ff.io_stb;
    assign io_strobe_oe_n = st_ff.ctl_oe_n;
    assign rw = st_ff.rw;
    assign rw_oe_n = st_ff.ctl_oe_n;
    assign data_space_sel_n = st_ff.dsel;
    assign program_space_sel_n = st_ff.psel;
    assign io_space_sel_n = st_ff.isel;
    assign space_sel_oe_n = st_ff.ctl_oe_n;
    assign bus_grant_ack_n = st_ff.grant;
    assign bus_grant_ack_oe_n = st_ff.grant_oe_n;
    assign wait_states_done_n = st_ff.wdone;
    assign wait_states_done_oe_n = st_ff.wdone_oe_n;
    assign instr_fetch_n = st_ff.fetch;
    assign instr_fetch_oe_n = st_ff.fetch_oe_n;
endmodule
`default_nettype wire

// ---- include/ebc_pkg.sv ----
// package for the external bus control block
package ebc_pkg;
    localparam int WS_W = 3;
    localparam logic [WS_W-1:0] WS_READY_MIN = 3'h2;
    localparam logic [WS_W-1:0] WS_ZERO = 3'h0;
    localparam logic [WS_W-1:0] WS_ONE = 3'h1;
    localparam logic [1:0] SP_DATA = 2'h0;
    localparam logic [1:0] SP_PROG = 2'h1;
    localparam logic [1:0] SP_IO = 2'h2;
    localparam logic PIN_HIGH = 1'h1;
    localparam logic PIN_LOW = 1'h0;
    typedef enum logic [1:0] {
        EBC_IDLE = 2'b00,
        EBC_WAIT = 2'b01,
        EBC_READY = 2'b10,
        EBC_HOLD = 2'b11
    } ebc_state_t;
endpackage
